// *** design/dac_clock_data_consts.svh ***
// constants of the dual converter clocking and data input block
// assumes inclusion by bare name from the design module and the bench
`ifndef DAC_CLOCK_DATA_CONSTS_SVH
`define DAC_CLOCK_DATA_CONSTS_SVH

// ****************************************
// register map, byte addresses
// ****************************************
`define REG_CONTROL_ADDR    12'h000
`define REG_STATUS_ADDR     12'h004
`define REG_SAMPLES_ADDR    12'h008
`define AHB_SIZE_WORD       3'h2

// ****************************************
// reset values
// ****************************************
// no interpolation, 0 dB trim, converter on, not powered down
`define CTRL_RESET_VALUE    8'h48
`define GAIN_ZERO_CODE      5'h08

// ****************************************
// positions in the synchronised pin vector
// ****************************************
`define PIN_COUNT           22
`define PIN_PLL             21
`define PIN_DCLK            20
`define PIN_CPOS            19
`define PIN_CNEG            18
`define PIN_STROBE          17
`define PIN_ILEAVE          16
`define PIN_PORTA_MSB       15
`define PIN_PORTA_LSB       8
`define PIN_PORTB_MSB       7
`define PIN_PORTB_LSB       0

`endif

// *** design/dac_clock_data_pkg.sv ***
// types of the dual converter clocking and data input block
// assumes the constants header sits beside it
package dac_clock_data_pkg;

   // control word as captured from channel A port
   typedef struct packed {
      logic       power_down_bit;
      logic       converter_on;
      logic       second_filter_on;
      logic       first_filter_on;
      logic [3:0] gain_trim;
   } ctrl_word_type;

   // interpolation factor, one-hot
   typedef enum logic [2:0] {
      INTERP_1X = 3'h1,
      INTERP_2X = 3'h2,
      INTERP_4X = 3'h4
   } interp_type;

   // decoded operating mode shown to the converter side
   typedef struct packed {
      logic       multiplier_on;
      logic       multiplier_connected;
      logic       lock_valid;
      logic       data_clock_is_output;
      logic       standby;
      logic       powered_down;
      logic       filters_powered;
      interp_type interp;
   } mode_type;

   // one sample for each channel
   typedef struct packed {
      logic [7:0] chan_b;
      logic [7:0] chan_a;
   } sample_pair_type;

endpackage : dac_clock_data_pkg

// *** design/dual_dac_clock_and_data_input.sv ***
// clocking mode, sample capture and control word capture of a dual 8-bit converter
// assumes all pins come from outside the clock domain and toggle well below clock/4
//
// Behaviour
// - pll_on high turns the multiplier on
// - multiplier on: data clock pin is input, rate x2/x4
// - multiplier off: drive divided conversion clock out
// - 1x, multiplier off: conversion clock updates directly
// - 1x with multiplier: disconnect it, lock invalid
// - capture on rising edge, output next rising
// - control word captured on strobe falling edge
// - control capture independent of conversion clocks
// - interleave takes both channels from port A
// - interleave: B on falling, A on next rising
// - interleave: both outputs update together afterwards
// - filter bits select 1x, 2x or 4x
// - reset state: 1x, 0 dB, converter on
// - gain trim steps from +8 down to -7
//
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps

`include "dac_clock_data_consts.svh"

module dual_dac_clock_and_data_input
   import dac_clock_data_pkg::*;
(
   // system
   input  wire logic            clock,
   input  wire logic            rst_n,
   input  wire logic            ce,
   // ahb-lite slave
   input  wire logic            hsel,
   input  wire logic [31:0]     haddr,
   input  wire logic [1:0]      htrans,
   input  wire logic            hwrite,
   input  wire logic [2:0]      hsize,
   input  wire logic [31:0]     hwdata,
   input  wire logic            hready,
   output logic      [31:0]     hrdata,
   output logic                 hreadyout,
   output logic                 hresp,
   // device pins
   input  wire logic            pll_on,
   input  wire logic            data_clock_in,
   output logic                 data_clock_out,
   output logic                 data_clock_oe,
   input  wire logic            conv_clock_pos,
   input  wire logic            conv_clock_neg,
   input  wire logic            control_write_strobe_n,
   input  wire logic            interleave_select,
   input  wire logic [7:0]      port_a_data,
   input  wire logic [7:0]      port_b_data,
   // converter side
   output sample_pair_type      chan_out,
   output mode_type             mode_out,
   output logic signed [4:0]    gain_steps,
   output logic                 conv_tick
);

   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [`PIN_COUNT-1:0] pins_raw;
   logic [`PIN_COUNT-1:0] sync1_reg;
   logic [`PIN_COUNT-1:0] sync2_reg;
   logic [`PIN_COUNT-1:0] sync3_reg;
   logic [`PIN_COUNT-1:0] pin_reg;
   logic [`PIN_COUNT-1:0] pin_prev_reg;

   assign pins_raw = {pll_on, data_clock_in, conv_clock_pos, conv_clock_neg,
                      control_write_strobe_n, interleave_select, port_a_data, port_b_data};

   // a level counts only once stages two and three agree
   genvar i;
   generate
      for (i = 0; i < `PIN_COUNT; i++)
      begin : g_sync
         always_ff @(posedge clock or negedge rst_n)
         begin
            if (!rst_n)
            begin
               sync1_reg[i] <= 1'b0;
               sync2_reg[i] <= 1'b0;
               sync3_reg[i] <= 1'b0;
               pin_reg[i]   <= 1'b0;
            end
            else if (ce)
            begin
               sync1_reg[i] <= pins_raw[i];
               sync2_reg[i] <= sync1_reg[i];
               sync3_reg[i] <= sync2_reg[i];
               if (sync2_reg[i] == sync3_reg[i])
                  pin_reg[i] <= sync3_reg[i];
            end
         end
      end
   endgenerate

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         pin_prev_reg <= '0;
      else if (ce)
         pin_prev_reg <= pin_reg;
   end

   wire logic       pll_f      = pin_reg[`PIN_PLL];
   wire logic       ileave_f   = pin_reg[`PIN_ILEAVE];
   wire logic [7:0] port_a_f   = pin_reg[`PIN_PORTA_MSB:`PIN_PORTA_LSB];
   wire logic [7:0] port_b_f   = pin_reg[`PIN_PORTB_MSB:`PIN_PORTB_LSB];
   wire logic       conv_rise  = pin_reg[`PIN_CPOS] & ~pin_prev_reg[`PIN_CPOS];
   // strobe is seen on the system clock, never on a conversion clock
   wire logic       strobe_fall = ~pin_reg[`PIN_STROBE] & pin_prev_reg[`PIN_STROBE];
   wire logic       diff_parked = ~pin_reg[`PIN_CPOS] & pin_reg[`PIN_CNEG];

   // ****************************************
   // register bus and control word
   // ****************************************
   ctrl_word_type ctrl_reg;
   ctrl_word_type ctrl_next;
   logic          wr_pending_reg;
   logic [11:0]   wr_addr_reg;
   logic [31:0]   hrdata_reg;
   logic          hreadyout_reg;

   mode_type        mode_out_reg;
   sample_pair_type chan_out_reg;
   logic [1:0]      div_cnt_reg;

   wire logic        ahb_take   = hsel & hready & htrans[1];
   wire logic        ahb_wr_req = ahb_take & hwrite & (hsize == `AHB_SIZE_WORD);
   wire logic [11:0] ahb_addr   = haddr[11:0];
   wire logic        ctrl_wr    = wr_pending_reg & (wr_addr_reg == `REG_CONTROL_ADDR);
   wire logic [31:0] status_word = {18'h0, div_cnt_reg, ileave_f, diff_parked, mode_out_reg};
   wire logic [31:0] read_word  =
      (ahb_addr == `REG_CONTROL_ADDR) ? {24'h0, ctrl_reg} :
      (ahb_addr == `REG_STATUS_ADDR)  ? status_word :
      (ahb_addr == `REG_SAMPLES_ADDR) ? {16'h0, chan_out_reg} : 32'h0;

   // the pin strobe wins over a bus write arriving in the same cycle
   assign ctrl_next = strobe_fall ? ctrl_word_type'(port_a_f) :
                      ctrl_wr     ? ctrl_word_type'(hwdata[7:0]) : ctrl_reg;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_reg       <= ctrl_word_type'(`CTRL_RESET_VALUE);
         wr_pending_reg <= 1'b0;
         wr_addr_reg    <= 12'h000;
         hrdata_reg     <= 32'h0;
         hreadyout_reg  <= 1'b1;
      end
      else if (ce)
      begin
         ctrl_reg       <= ctrl_next;
         wr_pending_reg <= ahb_wr_req;
         wr_addr_reg    <= ahb_addr;
         hrdata_reg     <= (ahb_take & ~hwrite) ? read_word : 32'h0;
         hreadyout_reg  <= 1'b1;
      end
   end

   assign hrdata    = hrdata_reg;
   assign hreadyout = hreadyout_reg;
   assign hresp     = 1'b0;

   // ****************************************
   // mode decode
   // ****************************************
   // the illegal second-only setting falls back to bypass
   wire interp_type interp_sel =
      (ctrl_reg.second_filter_on & ctrl_reg.first_filter_on) ? INTERP_4X :
      ctrl_reg.first_filter_on ? INTERP_2X : INTERP_1X;
   wire logic filters_on = (interp_sel != INTERP_1X);
   mode_type mode_next;

   always_comb
   begin
      mode_next.multiplier_on        = pll_f;
      mode_next.multiplier_connected = pll_f & filters_on;
      mode_next.lock_valid           = pll_f & filters_on;
      mode_next.data_clock_is_output = ~pll_f;
      mode_next.standby              = ~ctrl_reg.power_down_bit & ~ctrl_reg.converter_on;
      mode_next.powered_down         = ctrl_reg.power_down_bit;
      mode_next.filters_powered      = filters_on;
      mode_next.interp               = interp_sel;
   end

   // ****************************************
   // data clock generation and selection
   // ****************************************
   logic data_clock_out_reg;
   logic data_clock_oe_reg;
   logic dclk_prev_reg;
   logic conv_tick_reg;
   logic signed [4:0] gain_steps_reg;

   // counter keeps running in every mode so the divided edge phase never slips
   wire logic div_level = (interp_sel == INTERP_4X) ? div_cnt_reg[1] :
                          (interp_sel == INTERP_2X) ? div_cnt_reg[0] :
                          pin_reg[`PIN_CPOS];
   // with the multiplier on the pin is the data clock, else our own output is
   wire logic dclk_level = pll_f ? pin_reg[`PIN_DCLK] : data_clock_out_reg;
   wire logic dclk_rise  = dclk_level & ~dclk_prev_reg;
   wire logic dclk_fall  = ~dclk_level & dclk_prev_reg;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_cnt_reg        <= 2'h0;
         data_clock_out_reg <= 1'b0;
         data_clock_oe_reg  <= 1'b0;
         dclk_prev_reg      <= 1'b0;
         conv_tick_reg      <= 1'b0;
         mode_out_reg       <= {7'h08, INTERP_1X};
         gain_steps_reg     <= 5'sh0;
      end
      else if (ce)
      begin
         if (conv_rise)
            div_cnt_reg <= div_cnt_reg + 2'h1;
         data_clock_out_reg <= pll_f ? 1'b0 : div_level;
         data_clock_oe_reg  <= ~pll_f;
         dclk_prev_reg      <= dclk_level;
         conv_tick_reg      <= pll_f ? dclk_rise : conv_rise;
         mode_out_reg       <= mode_next;
         gain_steps_reg     <= `GAIN_ZERO_CODE - {1'b0, ctrl_reg.gain_trim};
      end
   end

   assign data_clock_out = data_clock_out_reg;
   assign data_clock_oe  = data_clock_oe_reg;
   assign conv_tick      = conv_tick_reg;
   assign mode_out       = mode_out_reg;
   assign gain_steps     = gain_steps_reg;

   // ****************************************
   // sample capture
   // ****************************************
   sample_pair_type stage_reg;
   logic [7:0]      b_hold_reg;

   // interleave takes B from port A on the falling edge; A comes on the next rise
   wire sample_pair_type stage_next = ileave_f ? {b_hold_reg, port_a_f}
                                               : {port_b_f, port_a_f};

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage_reg    <= '0;
         b_hold_reg   <= 8'h00;
         chan_out_reg <= '0;
      end
      else if (ce)
      begin
         if (dclk_fall & ileave_f)
            b_hold_reg <= port_a_f;
         if (dclk_rise)
         begin
            stage_reg    <= stage_next;
            chan_out_reg <= stage_reg;
         end
      end
   end

   assign chan_out = chan_out_reg;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   property p_multiplier_follows;
      ce |=> mode_out_reg.multiplier_on == $past(pll_f);
   endproperty
   a_multiplier_follows: assert property (p_multiplier_follows)
      else $error("multiplier flag not set after pll_on");

   property p_dclk_input;
      ce && pll_f |=> !data_clock_oe_reg && !data_clock_out_reg;
   endproperty
   a_dclk_input: assert property (p_dclk_input)
      else $error("data clock driven while multiplier on");

   property p_div_phase;
      // a mode or pll switch may move the output without a conversion edge
      $rose(data_clock_out_reg) && $stable(mode_out_reg.interp)
         && $stable(mode_out_reg.data_clock_is_output)
         && mode_out_reg.interp != INTERP_1X |-> $past(conv_rise, 2);
   endproperty
   a_div_phase: assert property (p_div_phase)
      else $error("divided clock rose without conversion edge");

   property p_capture;
      ce && dclk_rise && !ileave_f |=> stage_reg.chan_a == $past(port_a_f)
                                    && stage_reg.chan_b == $past(port_b_f);
   endproperty
   a_capture: assert property (p_capture)
      else $error("sample not captured on rising edge");

   property p_out_only_on_rise;
      $changed(chan_out_reg) |-> $past(dclk_rise) && $past(ce);
   endproperty
   a_out_only_on_rise: assert property (p_out_only_on_rise)
      else $error("outputs changed away from rising edge");

   property p_ilv_b;
      ce && dclk_fall && ileave_f |=> b_hold_reg == $past(port_a_f);
   endproperty
   a_ilv_b: assert property (p_ilv_b)
      else $error("channel B not taken on falling edge");

   property p_ilv_pair;
      ce && dclk_rise && ileave_f |=> stage_reg == {$past(b_hold_reg), $past(port_a_f)};
   endproperty
   a_ilv_pair: assert property (p_ilv_pair)
      else $error("interleave pair not taken from port A");

   property p_ctrl_capture;
      ce && strobe_fall |=> ctrl_reg == $past(port_a_f);
   endproperty
   a_ctrl_capture: assert property (p_ctrl_capture)
      else $error("control word not captured on strobe fall");

   property p_lock_invalid;
      ce && !ctrl_reg.first_filter_on |=>
         !mode_out_reg.lock_valid && !mode_out_reg.multiplier_connected;
   endproperty
   a_lock_invalid: assert property (p_lock_invalid)
      else $error("lock valid in 1x mode");

   property p_interp_4x;
      ce && ctrl_reg.second_filter_on && ctrl_reg.first_filter_on |=>
         mode_out_reg.interp == INTERP_4X && mode_out_reg.filters_powered;
   endproperty
   a_interp_4x: assert property (p_interp_4x)
      else $error("4x not decoded");

   property p_gain;
      ce |=> gain_steps_reg == `GAIN_ZERO_CODE - {1'b0, $past(ctrl_reg.gain_trim)};
   endproperty
   a_gain: assert property (p_gain)
      else $error("gain step wrong");

   c_ilv_update: cover property (ce && dclk_rise && ileave_f ##1 $changed(chan_out_reg));
   c_ctrl_write: cover property (ce && strobe_fall);
   c_div4_rise:  cover property ($rose(data_clock_out_reg) && mode_out_reg.interp == INTERP_4X);
   c_pll_capture: cover property (ce && pll_f && dclk_rise);

endmodule : dual_dac_clock_and_data_input

// *** tb/data_source_model.sv ***
// far-side data source: link clock, sample words, control word, conversion clock
// assumes the bench resolves the shared data clock pin and drives the strobe
`timescale 1ns/1ps

module data_source_model
(
   // mode pins shared with the device
   input  wire logic       pll_on,
   input  wire logic       interleave_select,
   // words to send
   input  wire logic       cw_en,
   input  wire logic [7:0] cw_val,
   input  wire logic [7:0] a_val,
   input  wire logic [7:0] b_val,
   // pins
   input  wire logic       data_clock_pin,
   output logic            src_clock,
   output logic            conv_clock_pos,
   output logic            conv_clock_neg,
   output logic [7:0]      port_a_data,
   output logic [7:0]      port_b_data
);
   logic [7:0] word_a = 8'h00;

   // ********************************
   // clocks and words
   // ********************************
   assign port_a_data = cw_en ? cw_val : word_a;

   // link clock runs only while the device takes it in; rate scaled to suit the sampler
   initial
   begin
      src_clock = 1'b0;
      #3;
      forever
      begin
         #62.5;
         src_clock = pll_on ? ~src_clock : 1'b0;
      end
   end

   initial
   begin
      conv_clock_pos = 1'b0;
      conv_clock_neg = 1'b1;
      port_b_data = 8'h00;
      #1;
      forever
      begin
         #100;
         conv_clock_pos = pll_on ? 1'b0 : ~conv_clock_pos;
         conv_clock_neg = ~conv_clock_pos;
      end
   end

   // words change well after the edge so the sampled copy keeps its hold time
   always @(negedge data_clock_pin)
   begin
      #20;
      word_a = a_val;
      port_b_data = interleave_select ? ~b_val : b_val;
   end

   always @(posedge data_clock_pin)
   begin
      #20;
      if (interleave_select)
      begin
         word_a = b_val;
         port_b_data = ~a_val;
      end
   end
endmodule : data_source_model

// *** tb/dual_dac_clock_and_data_input_tb.sv ***
// self-checking bench of the dual converter clocking and data input block
// assumes the package, the constants header and the data source model are compiled first
`timescale 1ns/1ps
`include "dac_clock_data_consts.svh"

module dual_dac_clock_and_data_input_tb;
   import dac_clock_data_pkg::*;

   logic              clock = 1'b0;
   logic              rst_n = 1'b0;
   logic              ce = 1'b1;
   logic              hsel = 1'b0;
   logic [31:0]       haddr = 32'h0;
   logic [1:0]        htrans = 2'h0;
   logic              hwrite = 1'b0;
   logic [2:0]        hsize = 3'h2;
   logic [31:0]       hwdata = 32'h0;
   logic              pll_on = 1'b0;
   logic              strobe_n = 1'b1;
   logic              ileave = 1'b0;
   logic              cw_en = 1'b0;
   logic [7:0]        cw_val = 8'h00;
   logic [7:0]        a_val = 8'h00;
   logic [7:0]        b_val = 8'h00;
   logic [31:0]       hrdata;
   logic              hreadyout;
   logic              hresp;
   logic              conv_tick;
   logic              data_clock_out;
   logic              data_clock_oe;
   logic              src_clock;
   logic              cpos;
   logic              cneg;
   logic [7:0]        port_a;
   logic [7:0]        port_b;
   sample_pair_type   chan_out;
   mode_type          mode_out;
   logic signed [4:0] gain_steps;
   logic              data_clock_pin;
   logic [31:0]       rdata;
   int                cyc = 0;
   int                num_errors = 0;
   int                cmp_count = 0;
   int                ticks = 0;
   int                tick_base = 0;
   logic [7:0]        codes [4] = '{8'h48, 8'h58, 8'h78, 8'h88};
   interp_type        modes [4] = '{INTERP_1X, INTERP_2X, INTERP_4X, INTERP_1X};
   int                periods [4] = '{20, 40, 80, 20};
   logic [3:0]        gains [3] = '{4'h0, 4'h8, 4'hf};
   logic [4:0]        steps [3] = '{5'h08, 5'h00, 5'h19};

   // the shared pin follows whichever side has it enabled
   assign data_clock_pin = data_clock_oe ? data_clock_out : src_clock;

   always #5 clock = ~clock;

   dual_dac_clock_and_data_input dual_dac_clock_and_data_input_inst
   (
      .clock(clock), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pll_on(pll_on), .data_clock_in(data_clock_pin),
      .data_clock_out(data_clock_out), .data_clock_oe(data_clock_oe), .conv_clock_pos(cpos),
      .conv_clock_neg(cneg), .control_write_strobe_n(strobe_n), .interleave_select(ileave),
      .port_a_data(port_a), .port_b_data(port_b), .chan_out(chan_out), .mode_out(mode_out),
      .gain_steps(gain_steps), .conv_tick(conv_tick)
   );

   data_source_model data_source_model_inst
   (
      .pll_on(pll_on), .interleave_select(ileave), .cw_en(cw_en), .cw_val(cw_val),
      .a_val(a_val), .b_val(b_val), .data_clock_pin(data_clock_pin), .src_clock(src_clock),
      .conv_clock_pos(cpos), .conv_clock_neg(cneg), .port_a_data(port_a), .port_b_data(port_b)
   );

   // ********************************
   // tasks
   // ********************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask : check

   // periods are counted in sampler cycles, so one cycle of slack is allowed
   task automatic check_near(input int got, input int exp);
      cmp_count++;
      if (got < exp - 1 || got > exp + 1)
      begin
         num_errors++;
         $display("Error at %0t ns: period %0d, expected %0d", $time, got, exp);
      end
   endtask : check_near

   // only the bench timeout ends a wait that never sees ready
   task automatic wait_ready;
      @(posedge clock);
      while (hreadyout !== 1'b1)
         @(posedge clock);
   endtask : wait_ready

   task automatic bus(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h0, addr};
      hwrite <= wr;
      hsize <= 3'h2;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wdata;
      wait_ready();
      rdata = hrdata;
   endtask : bus

   task automatic settle;
      repeat (12) @(posedge clock);
   endtask : settle

   // lag: the rise that takes the new pair must still show the old one
   task automatic send_check(input logic [7:0] a, input logic [7:0] b, input logic lag);
      logic [15:0] old;
      old = chan_out;
      @(posedge data_clock_pin);
      @(posedge clock);
      a_val <= a;
      b_val <= b;
      @(posedge data_clock_pin);
      repeat (6) @(posedge clock);
      if (lag)
         check({16'h0, chan_out}, {16'h0, old});
      repeat (3) @(posedge data_clock_pin);
      repeat (6) @(posedge clock);
      check({16'h0, chan_out}, {16'h0, b, a});
   endtask : send_check

   task automatic check_period(input int exp);
      int t0;
      @(posedge data_clock_out);
      @(posedge data_clock_out);
      t0 = cyc;
      @(posedge data_clock_out);
      check_near(cyc - t0, exp);
      @(posedge clock);
   endtask : check_period

   task tally_and_finish;
      $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish

   // the whole sequence needs well under a tenth of this
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (conv_tick === 1'b1)
         ticks <= ticks + 1;
      if (cyc == 40000)
      begin
         num_errors++;
         tally_and_finish();
      end
   end

   // ********************************
   // sequence
   // ********************************
   initial
   begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      settle();
      bus(1'b0, `REG_CONTROL_ADDR, 32'h0);
      check(rdata, 32'h48);
      check({27'h0, gain_steps}, 32'h0);
      check({29'h0, mode_out.interp}, {29'h0, INTERP_1X});
      bus(1'b0, 12'h00c, 32'h0);
      check(rdata, 32'h0);
      check({31'h0, hresp}, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b1, `REG_CONTROL_ADDR, {24'h0, codes[i]});
         bus(1'b0, `REG_CONTROL_ADDR, 32'h0);
         check(rdata, {24'h0, codes[i]});
         settle();
         check({29'h0, mode_out.interp}, {29'h0, modes[i]});
         check({31'h0, data_clock_oe}, 32'h1);
         check_period(periods[i]);
      end
      for (int i = 0; i < 3; i++)
      begin
         bus(1'b1, `REG_CONTROL_ADDR, {28'h4, gains[i]});
         repeat (2) @(posedge clock);
         check({27'h0, gain_steps}, {27'h0, steps[i]});
      end
      cw_val <= 8'h5f;
      cw_en <= 1'b1;
      settle();
      strobe_n <= 1'b0;
      settle();
      strobe_n <= 1'b1;
      settle();
      cw_en <= 1'b0;
      bus(1'b0, `REG_CONTROL_ADDR, 32'h0);
      check(rdata, 32'h5f);
      check({29'h0, mode_out.interp}, {29'h0, INTERP_2X});
      send_check(8'h3c, 8'hc3, 1'b0);
      send_check(8'ha5, 8'h5a, 1'b1);
      bus(1'b0, `REG_SAMPLES_ADDR, 32'h0);
      check(rdata, 32'h5aa5);
      pll_on <= 1'b1;
      settle();
      check({31'h0, mode_out.multiplier_on}, 32'h1);
      check({31'h0, mode_out.multiplier_connected}, 32'h1);
      check({30'h0, data_clock_oe, data_clock_out}, 32'h0);
      send_check(8'h81, 8'h7e, 1'b1);
      // divider count bits are free-running, so they are masked out
      bus(1'b0, `REG_STATUS_ADDR, 32'h0);
      check(rdata & 32'hffff_cfff, 32'h0000_078a);
      ileave <= 1'b1;
      settle();
      send_check(8'h12, 8'hed, 1'b0);
      send_check(8'hf0, 8'h0f, 1'b0);
      ileave <= 1'b0;
      bus(1'b1, `REG_CONTROL_ADDR, 32'h48);
      settle();
      check({30'h0, mode_out.multiplier_connected, mode_out.lock_valid}, 32'h0);
      send_check(8'h55, 8'haa, 1'b1);
      pll_on <= 1'b0;
      settle();
      check({31'h0, mode_out.multiplier_on}, 32'h0);
      send_check(8'h01, 8'h80, 1'b1);
      // one conversion tick per conversion clock period of 20 cycles
      tick_base = ticks;
      repeat (200) @(posedge clock);
      check_near(ticks - tick_base, 10);
      tally_and_finish();
   end
endmodule : dual_dac_clock_and_data_input_tb
